// [inc/hub_cfg_pkg.sv]
package hub_cfg_pkg;
  // apb register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] ROUTE_ADDR  = 8'h08;
  localparam logic [7:0] LINK_ADDR   = 8'h0c;
  localparam logic [7:0] NRPORT_ADDR = 8'h10;
  localparam logic [7:0] LED_ADDR    = 8'h14;
  // ctrl fields
  localparam int CTRL_U12_EN   = 0;
  localparam int CTRL_LED_AUTO = 1;
  localparam int CTRL_SUSPEND  = 2;
  localparam int CTRL_REJECT   = 3;
  localparam int CTRL_SS_MODE  = 4;
  // link fields
  localparam int LINK_U3_REQ   = 0;
  localparam int LINK_U0_REQ   = 1;
  // timing
  localparam int CLK_MHZ        = 50;
  localparam int RST_DELAY_US   = 40;
  localparam int RST_DELAY_CYC  = RST_DELAY_US * CLK_MHZ;
  localparam int U1_IDLE_CYC    = 16;
  localparam int U2_IDLE_CYC    = 64;
  localparam int RST_CNT_W      = 12;
  localparam int IDLE_CNT_W     = 8;
  localparam int NPORT          = 4;
  // link power states, gray along u0-u1-u2-u3
  typedef enum logic [1:0] {
    LINK_U0 = 2'b00,
    LINK_U1 = 2'b01,
    LINK_U2 = 2'b11,
    LINK_U3 = 2'b10
  } link_state_t;
  // per-port route selection
  localparam logic ROUTE_REPEATER = 1'b0;
  localparam logic ROUTE_TT       = 1'b1;
endpackage

// [verilog/hub_cfg_route.sv]
`timescale 1ns/100ps
// Behaviour
// - upstream uses full speed on a 1.1 parent, high speed on 2.0
// - in 1.1 mode every port routes through the repeater
// - in 2.0 mode high-speed downstream devices route through repeater
// - in 2.0 mode full or low speed devices route through translator
// - one shared translator buffer control serves all downstream ports
// - wakeup while globally suspended raises an internal resume pulse
// - superspeed link power states U0, U1, U2 and U3 supported
// - device enters U1 then U2 itself when enabled and link idle
// - partner U1/U2 requests accepted or rejected by internal condition
// - chip reset from external reset pin or internal power-good loss
// - reset released about 40 microseconds after power good
// - suspend indicator asserted as soon as hub is globally suspended
// - port indicators follow hub flow, manual and automatic modes
// - indicator lighting switched off while globally suspended
// - polarity strap 0 gives active-high, 1 gives active-low enables
// - self power strap selects bus-powered or self-powered hub
// - strap can disable downstream port 4
// - non-removable ports set by firmware together with strap
// - charging logic runs handshake with compliant portable device
// - charge strap low disables, high enables charging on every port not disabled by strap
module hub_cfg_route #(
  parameter int RST_CYC = hub_cfg_pkg::RST_DELAY_CYC,
  parameter int NPORT   = hub_cfg_pkg::NPORT
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             external_reset_n_in,
  input  wire logic             power_good_in,
  // apb slave
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  // straps and pins
  input  wire logic             switch_polarity_strap_in,
  input  wire logic             self_power_select_in,
  input  wire logic             port4_disable_strap_in,
  input  wire logic [NPORT-1:0] nonremovable_strap_in,
  input  wire logic             indicator_charge_strap_pin_in,
  // link status
  input  wire logic             upstream_is_usb2_in,
  input  wire logic [NPORT-1:0] downstream_port_hs_in,
  input  wire logic [NPORT-1:0] wakeup_event_in,
  input  wire logic             traffic_pending_in,
  input  wire logic             partner_lp_req_in,
  input  wire logic [NPORT-1:0] charge_dp_src_in,
  // outputs
  output logic                  chip_rst_n_out,
  output logic                  upstream_hs_out,
  output logic      [NPORT-1:0] route_tt_out,
  output logic                  tt_busy_out,
  output logic                  resume_out,
  output logic      [1:0]       link_state_out,
  output logic                  lp_accept_out,
  output logic                  lp_reject_out,
  output logic                  suspend_indicator_out,
  output logic      [NPORT-1:0] port_led_out,
  output logic      [NPORT-1:0] power_enable_out,
  output logic                  self_powered_out,
  output logic      [NPORT-1:0] port_active_out,
  output logic      [NPORT-1:0] nonremovable_out,
  output logic      [NPORT-1:0] charge_dm_src_out
);

  typedef struct packed {
    logic [1:0]                   ext_sync;
    logic [1:0]                   pg_sync;
    logic [hub_cfg_pkg::RST_CNT_W-1:0] rst_cnt;
    logic                         chip_rst_n;
    logic                         straps_taken;
    logic                         pol;
    logic                         self_pwr;
    logic                         p4_dis;
    logic [NPORT-1:0]             nr_strap;
    logic                         chg_en;
    logic [4:0]                   ctrl;
    logic [NPORT-1:0]             pwr_req;
    logic [NPORT-1:0]             nr_fw;
    logic [NPORT-1:0]             led_man;
    logic [NPORT-1:0]             led_auto;
    hub_cfg_pkg::link_state_t     link;
    logic [hub_cfg_pkg::IDLE_CNT_W-1:0] idle_cnt;
    logic [NPORT+3:0]             strap_m;
    logic [NPORT+3:0]             strap_s;
    logic [NPORT-1:0]             dm_src;
    logic                         tt_busy;
    logic [NPORT-1:0]             pwr_en;
    logic [NPORT-1:0]             nr_out;
    logic [NPORT-1:0]             tt_sel;
    logic                         us_hs;
    logic                         resume;
    logic                         acc;
    logic                         rej;
    logic [NPORT-1:0]             ren;
    logic [NPORT-1:0]             led;
    logic                         susp_led;
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         err;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   access;

  // an apb access phase; slave answers in the second access cycle
  // the ready flop masks the second access cycle, so a master that
  // holds the request until it sees pready cannot write twice
  assign access = psel_in & penable_in & ~s_q.ready;

  // low-power entry permitted by software: enable bit in superspeed
  // used for both self-initiated and partner-initiated entry
  function automatic logic lp_enabled(input logic [4:0] ctrl);
    return ctrl[hub_cfg_pkg::CTRL_U12_EN] &
           ctrl[hub_cfg_pkg::CTRL_SS_MODE];
  endfunction

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for the async reset sources
    s_d.ext_sync = {s_q.ext_sync[0], external_reset_n_in};
    s_d.pg_sync  = {s_q.pg_sync[0], power_good_in};
    if (!s_q.ext_sync[1] || !s_q.pg_sync[1]) begin
      s_d.rst_cnt    = '0;
      s_d.chip_rst_n = 1'b0;
    end else if (s_q.rst_cnt < RST_CYC[hub_cfg_pkg::RST_CNT_W-1:0]) begin
      s_d.rst_cnt = s_q.rst_cnt + 1'b1;
    end else begin
      s_d.chip_rst_n = 1'b1;
    end
    // strap pins are board levels, so they pass two flops first;
    // a strap moving during the counter settles long before release
    s_d.strap_m = {switch_polarity_strap_in, self_power_select_in,
                   port4_disable_strap_in, indicator_charge_strap_pin_in,
                   nonremovable_strap_in};
    s_d.strap_s = s_q.strap_m;
    // strap capture once at release; straps are static levels
    // later strap moves are ignored until the next chip reset
    if (!s_q.chip_rst_n) begin
      s_d.straps_taken = 1'b0;
    end else if (!s_q.straps_taken) begin
      s_d.straps_taken = 1'b1;
      s_d.pol          = s_q.strap_s[NPORT+3];
      s_d.self_pwr     = s_q.strap_s[NPORT+2];
      s_d.p4_dis       = s_q.strap_s[NPORT+1];
      s_d.chg_en       = s_q.strap_s[NPORT];
      s_d.nr_strap     = s_q.strap_s[NPORT-1:0];
    end
    s_d.us_hs = upstream_is_usb2_in;
    for (int i = 0; i < NPORT; i++) begin
      s_d.tt_sel[i] = upstream_is_usb2_in & ~downstream_port_hs_in[i];
    end
    // single shared translator busy when any port uses it
    // one buffer control serves all ports, so busy is a plain or
    s_d.tt_busy = |s_q.tt_sel;
    s_d.resume = s_q.ctrl[hub_cfg_pkg::CTRL_SUSPEND] & (|wakeup_event_in);
    s_d.acc = 1'b0;
    s_d.rej = 1'b0;
    if (traffic_pending_in) begin
      s_d.idle_cnt = '0;
    end else if (s_q.idle_cnt != '1) begin
      s_d.idle_cnt = s_q.idle_cnt + 1'b1;
    end
    if (!s_q.ctrl[hub_cfg_pkg::CTRL_SS_MODE]) begin
      s_d.link = hub_cfg_pkg::LINK_U0;
    end else begin
      case (s_q.link)
        hub_cfg_pkg::LINK_U0: begin
          if (partner_lp_req_in) begin
            // accept only when idle, enabled and not forced off
            if (lp_enabled(s_q.ctrl) &&
                !s_q.ctrl[hub_cfg_pkg::CTRL_REJECT] &&
                !traffic_pending_in) begin
              s_d.acc  = 1'b1;
              s_d.link = hub_cfg_pkg::LINK_U1;
            end else begin
              s_d.rej = 1'b1;
            end
          // self-initiated entry
          // an idle count left from before an exit re-enters at once;
          // that is intended, the link really has been quiet that long
          end else if (lp_enabled(s_q.ctrl) &&
              s_q.idle_cnt >= hub_cfg_pkg::IDLE_CNT_W'(
                hub_cfg_pkg::U1_IDLE_CYC)) begin
            s_d.link = hub_cfg_pkg::LINK_U1;
          end
        end
        hub_cfg_pkg::LINK_U1: begin
          if (traffic_pending_in) begin
            s_d.link = hub_cfg_pkg::LINK_U0;
          end else if (s_q.idle_cnt >= hub_cfg_pkg::IDLE_CNT_W'(
              hub_cfg_pkg::U2_IDLE_CYC)) begin
            s_d.link = hub_cfg_pkg::LINK_U2;
          end
        end
        hub_cfg_pkg::LINK_U2: begin
          if (traffic_pending_in) begin
            s_d.link = hub_cfg_pkg::LINK_U0;
          end
        end
        hub_cfg_pkg::LINK_U3: begin
          if (|wakeup_event_in) begin
            s_d.link = hub_cfg_pkg::LINK_U0;
          end
        end
        default: s_d.link = hub_cfg_pkg::LINK_U0;
      endcase
    end
    // charging handshake: answer dm while device drives dp
    for (int i = 0; i < NPORT; i++) begin
      s_d.dm_src[i] = s_q.chg_en & charge_dp_src_in[i] & s_q.ren[i];
    end
    s_d.ren = '1;
    if (s_q.p4_dis) begin
      s_d.ren[NPORT-1] = 1'b0;
    end
    for (int i = 0; i < NPORT; i++) begin
      s_d.led[i] = ~s_q.ctrl[hub_cfg_pkg::CTRL_SUSPEND] & s_q.ren[i] &
        (s_q.ctrl[hub_cfg_pkg::CTRL_LED_AUTO] ? s_q.led_auto[i]
                                             : s_q.led_man[i]);
    end
    s_d.susp_led = s_q.ctrl[hub_cfg_pkg::CTRL_SUSPEND];
    // polarity from strap, registered so the pins never glitch
    s_d.pwr_en = s_q.pol ? ~(s_q.pwr_req & s_q.ren)
                         : (s_q.pwr_req & s_q.ren);
    s_d.nr_out = s_q.nr_fw & s_q.nr_strap;
    // apb answer
    s_d.ready = access;
    s_d.err   = 1'b0;
    s_d.rdata = '0;
    if (access) begin
      case (paddr_in)
        hub_cfg_pkg::CTRL_ADDR: begin
          if (pwrite_in) begin
            s_d.ctrl = pwdata_in[4:0];
          end
          s_d.rdata = {27'h0, s_q.ctrl};
        end
        hub_cfg_pkg::STATUS_ADDR: begin
          s_d.rdata = {24'h0, s_q.chg_en, s_q.p4_dis, s_q.self_pwr,
                       s_q.pol, s_q.us_hs, s_q.link, s_q.chip_rst_n};
        end
        hub_cfg_pkg::ROUTE_ADDR: begin
          s_d.rdata = {{(32-NPORT){1'b0}}, s_q.tt_sel};
        end
        hub_cfg_pkg::LINK_ADDR: begin
          if (pwrite_in && pwdata_in[hub_cfg_pkg::LINK_U3_REQ]) begin
            s_d.link = hub_cfg_pkg::LINK_U3;
          end else if (pwrite_in && pwdata_in[hub_cfg_pkg::LINK_U0_REQ])
          begin
            s_d.link = hub_cfg_pkg::LINK_U0;
          end
          s_d.rdata = {30'h0, s_q.link};
        end
        hub_cfg_pkg::NRPORT_ADDR: begin
          if (pwrite_in) begin
            s_d.nr_fw   = pwdata_in[NPORT-1:0];
            s_d.pwr_req = pwdata_in[2*NPORT-1:NPORT];
          end
          s_d.rdata = {{(32-2*NPORT){1'b0}}, s_q.pwr_req, s_q.nr_fw};
        end
        hub_cfg_pkg::LED_ADDR: begin
          if (pwrite_in) begin
            s_d.led_man  = pwdata_in[NPORT-1:0];
            s_d.led_auto = pwdata_in[2*NPORT-1:NPORT];
          end
          s_d.rdata = {{(32-2*NPORT){1'b0}}, s_q.led_auto, s_q.led_man};
        end
        default: s_d.err = 1'b1; // unmapped address
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign prdata_out            = s_q.rdata;
  assign pready_out            = s_q.ready;
  assign pslverr_out           = s_q.err;
  assign chip_rst_n_out        = s_q.chip_rst_n;
  assign upstream_hs_out       = s_q.us_hs;
  assign route_tt_out          = s_q.tt_sel;
  assign tt_busy_out           = s_q.tt_busy;
  assign resume_out            = s_q.resume;
  assign link_state_out        = s_q.link;
  assign lp_accept_out         = s_q.acc;
  assign lp_reject_out         = s_q.rej;
  assign suspend_indicator_out = s_q.susp_led;
  assign port_led_out          = s_q.led;
  assign power_enable_out      = s_q.pwr_en;
  assign self_powered_out      = s_q.self_pwr;
  assign port_active_out       = s_q.ren;
  assign nonremovable_out      = s_q.nr_out;
  assign charge_dm_src_out     = s_q.dm_src;

endmodule // hub_cfg_route

// [bench/hub_cfg_route_properties.sv]
`timescale 1ns/100ps
module hub_cfg_route_properties #(
  parameter int RST_CYC = hub_cfg_pkg::RST_DELAY_CYC
) (
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       external_reset_n_in,
  input wire logic       power_good_in,
  input wire logic       upstream_is_usb2_in,
  input wire logic [3:0] downstream_port_hs_in,
  input wire logic [3:0] wakeup_event_in,
  input wire logic       partner_lp_req_in,
  input wire logic       chip_rst_n_out,
  input wire logic       upstream_hs_out,
  input wire logic [3:0] route_tt_out,
  input wire logic       resume_out,
  input wire logic [1:0] link_state_out,
  input wire logic       lp_accept_out,
  input wire logic       lp_reject_out,
  input wire logic       suspend_indicator_out,
  input wire logic [3:0] port_led_out
);
  int ok_q;
  // cycles since both reset sources went inactive, saturating
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ok_q <= 0;
    end else if (!(power_good_in && external_reset_n_in)) begin
      ok_q <= 0;
    end else if (ok_q < 4000) begin
      ok_q <= ok_q + 1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_us_hs; (chip_rst_n_out && upstream_is_usb2_in)[*3] |-> upstream_hs_out; endproperty
  a_us_hs: assert property (p_us_hs) else $error("no hs upstream");
  property p_rpt; (chip_rst_n_out && !upstream_is_usb2_in)[*3] |-> !upstream_hs_out && route_tt_out == 4'h0; endproperty
  a_rpt: assert property (p_rpt) else $error("fs mode routing");
  property p_route; (chip_rst_n_out && upstream_is_usb2_in && $stable(downstream_port_hs_in))[*3] |-> route_tt_out == ~downstream_port_hs_in; endproperty
  a_route: assert property (p_route) else $error("hs mode routing");
  property p_resume; suspend_indicator_out && |wakeup_event_in |-> ##[0:3] resume_out; endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_led_off; suspend_indicator_out [*2] |-> port_led_out == 4'h0; endproperty
  a_led_off: assert property (p_led_off) else $error("led lit");
  property p_lp_ans; $rose(partner_lp_req_in) |-> ##[1:4] (lp_accept_out || lp_reject_out); endproperty
  a_lp_ans: assert property (p_lp_ans) else $error("no lp answer");
  property p_lp_u1; lp_accept_out |-> ##[0:2] link_state_out == hub_cfg_pkg::LINK_U1; endproperty
  a_lp_u1: assert property (p_lp_u1) else $error("accept not u1");
  property p_rst_pg; !power_good_in |-> ##[1:6] !chip_rst_n_out; endproperty
  a_rst_pg: assert property (p_rst_pg) else $error("no chip reset");
  property p_rst_rel; $rose(chip_rst_n_out) |-> ok_q >= RST_CYC && ok_q <= RST_CYC + 8; endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("release time");
endmodule // hub_cfg_route_properties
bind hub_cfg_route hub_cfg_route_properties #(.RST_CYC(RST_CYC)) i_props (.*);

// [bench/hub_host_model.sv]
`timescale 1ns/100ps
module hub_host_model (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic usb2_sel_in,
  input  wire logic lp_go_in,
  input  wire logic lp_accept_in,
  input  wire logic lp_reject_in,
  output logic      upstream_is_usb2_out,
  output logic      partner_lp_req_out,
  output logic [1:0] answer_out
);
  // parent generation chosen by the bench
  assign upstream_is_usb2_out = usb2_sel_in;
  // request held until the hub answers, answer kept for the bench
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      partner_lp_req_out <= 1'b0;
      answer_out <= 2'h0;
    end else if (lp_go_in) begin
      partner_lp_req_out <= 1'b1;
      answer_out <= 2'h0;
    end else if (partner_lp_req_out && (lp_accept_in || lp_reject_in)) begin
      partner_lp_req_out <= 1'b0;
      answer_out <= {lp_accept_in, lp_reject_in};
    end
  end
endmodule // hub_host_model

// [bench/hub_cfg_route_tb.sv]
`timescale 1ns/100ps
module hub_cfg_route_tb;
  localparam int RC = 20;
  logic clk_in = 0, nrst_in = 0, external_reset_n_in = 1, power_good_in = 1;
  logic psel_in = 0, penable_in = 0, pwrite_in = 0, pready_out, pslverr_out;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic switch_polarity_strap_in = 0, self_power_select_in = 1, er;
  logic port4_disable_strap_in = 0, indicator_charge_strap_pin_in = 1;
  logic traffic_pending_in = 1, usb2_sel = 0, lp_go = 0;
  logic upstream_is_usb2_in, partner_lp_req_in, chip_rst_n_out;
  logic [3:0] nonremovable_strap_in = 4'h3, downstream_port_hs_in = 4'h0;
  logic [3:0] wakeup_event_in = 4'h0, charge_dp_src_in = 4'h0;
  logic upstream_hs_out, tt_busy_out, resume_out, lp_accept_out;
  logic lp_reject_out, suspend_indicator_out, self_powered_out;
  logic [1:0] link_state_out, answer;
  logic [3:0] route_tt_out, port_led_out, power_enable_out, port_active_out;
  logic [3:0] nonremovable_out, charge_dm_src_out;
  int failures = 0, n_tests = 0, cyc = 0;
  hub_cfg_route #(.RST_CYC(RC)) i_hub_cfg_route (.*);
  hub_host_model i_hub_host_model (
    .clk_in(clk_in), .nrst_in(nrst_in), .usb2_sel_in(usb2_sel),
    .lp_go_in(lp_go), .lp_accept_in(lp_accept_out),
    .lp_reject_in(lp_reject_out), .upstream_is_usb2_out(upstream_is_usb2_in),
    .partner_lp_req_out(partner_lp_req_in), .answer_out(answer));
  always #10 clk_in = ~clk_in;
  // hang guard, run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // apb transfer, held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    wt(1);
    penable_in <= 1;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (pready_out !== 1'b1) begin
      failures++;
    end
    rd = prdata_out;
    er = pslverr_out;
    wt(1);
    psel_in <= 0;
    penable_in <= 0;
    wt(1);
  endtask
  task automatic lp(input logic [1:0] e);
    int n;
    lp_go <= 1;
    wt(1);
    lp_go <= 0;
    wt(1);
    n = 0;
    while (answer === 2'h0 && n < 20) begin
      wt(1);
      n++;
    end
    chk(answer, e);
  endtask
  task automatic t_reset;
    int n;
    external_reset_n_in <= 0;
    wt(RC + 10); // outlasts internal interval
    chk(chip_rst_n_out, 0);
    external_reset_n_in <= 1;
    n = 0;
    while (chip_rst_n_out !== 1'b1 && n < 200) begin
      wt(1);
      n++;
    end
    chk(n >= RC && n <= RC + 8, 1);
    power_good_in <= 0;
    wt(6);
    chk(chip_rst_n_out, 0);
    power_good_in <= 1;
    wt(RC + 10);
    $display("t_reset done");
  endtask
  task automatic t_route;
    downstream_port_hs_in <= 4'h5;
    wt(6);
    chk({upstream_hs_out, route_tt_out}, 5'h00);
    usb2_sel <= 1;
    wt(6);
    chk({upstream_hs_out, route_tt_out}, 5'h1a);
    apb(0, hub_cfg_pkg::ROUTE_ADDR, 32'h0);
    chk(rd[3:0], 4'ha);
    chk(tt_busy_out, 1);
    $display("t_route done");
  endtask
  task automatic t_link;
    apb(1, hub_cfg_pkg::CTRL_ADDR, 32'h11);
    lp(2'b01);
    apb(1, hub_cfg_pkg::CTRL_ADDR, 32'h19);
    traffic_pending_in <= 0;
    lp(2'b01);
    apb(1, hub_cfg_pkg::CTRL_ADDR, 32'h11);
    lp(2'b10);
    chk(link_state_out, hub_cfg_pkg::LINK_U1);
    traffic_pending_in <= 1;
    apb(1, hub_cfg_pkg::LINK_ADDR, 32'h2);
    wt(2);
    chk(link_state_out, hub_cfg_pkg::LINK_U0);
    traffic_pending_in <= 0;
    wt(hub_cfg_pkg::U1_IDLE_CYC + 4);
    chk(link_state_out, hub_cfg_pkg::LINK_U1);
    wt(hub_cfg_pkg::U2_IDLE_CYC + hub_cfg_pkg::U1_IDLE_CYC);
    chk(link_state_out, hub_cfg_pkg::LINK_U2);
    apb(1, hub_cfg_pkg::LINK_ADDR, 32'h1);
    apb(0, hub_cfg_pkg::LINK_ADDR, 32'h0);
    chk(rd[1:0], hub_cfg_pkg::LINK_U3);
    apb(1, hub_cfg_pkg::CTRL_ADDR, 32'h0);
    apb(1, hub_cfg_pkg::LINK_ADDR, 32'h2);
    $display("t_link done");
  endtask
  task automatic t_susp;
    apb(1, hub_cfg_pkg::LED_ADDR, 32'h35);
    wt(2);
    chk(port_led_out, 4'h5);
    apb(1, hub_cfg_pkg::CTRL_ADDR, 32'h2);
    wt(2);
    chk(port_led_out, 4'h3);
    apb(1, hub_cfg_pkg::CTRL_ADDR, 32'h6);
    wt(2);
    chk({suspend_indicator_out, port_led_out}, 5'h10);
    wakeup_event_in <= 4'h8;
    wt(3);
    chk(resume_out, 1);
    wakeup_event_in <= 4'h0;
    apb(1, hub_cfg_pkg::CTRL_ADDR, 32'h0);
    apb(1, 8'h40, 32'h1);
    chk(er, 1); // unmapped refused
    $display("t_susp done");
  endtask
  task automatic t_strap;
    apb(1, hub_cfg_pkg::NRPORT_ADDR, 32'h3f);
    charge_dp_src_in <= 4'h1;
    wt(8);
    chk(nonremovable_out, 4'h3);
    chk({self_powered_out, power_enable_out}, 5'h13);
    chk({port_active_out, charge_dm_src_out}, 8'hf1);
    nrst_in <= 0;
    switch_polarity_strap_in <= 1;
    self_power_select_in <= 0;
    port4_disable_strap_in <= 1;
    indicator_charge_strap_pin_in <= 0;
    downstream_port_hs_in <= 4'hf;
    wt(2);
    nrst_in <= 1;
    wt(RC + 10);
    apb(1, hub_cfg_pkg::NRPORT_ADDR, 32'h10);
    switch_polarity_strap_in <= 0;
    wt(4);
    chk({self_powered_out, power_enable_out}, 5'h0e);
    chk({port_active_out[3], charge_dm_src_out}, 5'h00);
    $display("t_strap done");
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    wt(20);
    nrst_in <= 1;
    wt(RC + 10);
    t_reset();
    t_route();
    t_link();
    t_susp();
    t_strap();
    final_report();
  end
endmodule // hub_cfg_route_tb
